// ---- logic/hps_selector.sv ----
`timescale 1ns/1ps
`default_nettype none
module hps_selector #(
    parameter int unsigned SETTLE_CYC = hps_pkg::SETTLE_CYCLES,
    parameter int unsigned UNPLUG_CYC = hps_pkg::UNPLUG_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic clkEn,
    input  wire logic sinkDetectA,      // pin
    input  wire logic sinkDetectB,      // pin
    input  wire logic prioritySelect,   // pin: 0 prefers A
    input  wire logic lowPowerRequest,  // pin, low requests sleep
    output logic      sourceDetect,     // repeated detect level
    output logic      portSelB,         // 0 = port A, 1 = port B
    output logic      linkEnable,       // 1 drives link and aux, 0 high impedance
    output logic      lowPowerState     // 1 while asleep
);
    // how the selector is put together:
    //  - every pin passes three flip-flops; a level is taken only once the
    //    second and third stage agree, so a one-sample spike never counts
    //  - the clean levels drive one small state machine with four modes:
    //    asleep, following a port, letting the priority pin settle, and
    //    holding the source detect low to mimic an unplug
    //  - one shared countdown serves both the settle wait and the forced
    //    low, since the two never run at once
    //  - a second counter measures how long the selected detect has been
    //    low, which tells a sink interrupt from a real unplug
    //  - all four outputs are flops, so the source never sees a decode
    //    glitch; the cost is one more cycle of latency
    //  - pin to output latency is five to six cycles, far below any
    //    detect pulse a sink is allowed to send
    //  - low pulses shorter than the sync window may vanish; that is
    //    accepted because the source need not see them faithfully
    //  - the low-power pin does not clear the port choice: with a sink
    //    present the port stays selected and repeated, only the I/O rests
    //  - a low clock enable freezes every stage, synchronisers included,
    //    so a frozen block resumes exactly where it stopped

    // end points of the two counters, cut to the timer width on purpose;
    // the defaults fit, a longer time needs a wider timer
    localparam int unsigned   TW          = hps_pkg::TIMER_W;
    localparam logic [TW-1:0] SETTLE_LAST = TW'(SETTLE_CYC - 1);  // last settle count
    localparam logic [TW-1:0] UNPLUG_LAST = TW'(UNPLUG_CYC - 1);  // last forced-low count
    localparam logic [TW-1:0] UNPLUG_LIM  = TW'(UNPLUG_CYC);      // low time meaning unplug

    // three-stage synchronisers, stage 0 takes the pin
    logic [2:0]          sA_r;          // sink detect a
    logic [2:0]          sB_r;          // sink detect b
    logic [2:0]          sP_r;          // priority select
    logic [2:0]          sL_r;          // low-power request
    hps_pkg::hps_in_t    in_r;          // accepted levels
    hps_pkg::hps_state_t state_r;       // selector mode
    logic [TW-1:0]       lowCnt_r;      // how long the selected detect is low
    logic [TW-1:0]       tmr_r;         // settle / forced-low count
    logic                prioSeen_r;    // priority level last acted on
    logic                lowPwrPrev_r;  // accepted low-power level one cycle back

    // decoded views of the accepted levels
    logic                selDet;        // detect of the selected port
    logic                othDet;        // detect of the other port
    logic                prefB;         // priority pin prefers port b
    logic                prefDet;       // detect of the preferred port
    logic                bothHigh;      // both sinks present
    logic                oneHigh;       // exactly one sink present
    logic                noneHigh;      // no sink present
    // decisions shared by the state, port and timer processes
    logic                bypassHit;     // low-power fall during forced low
    logic                sleepHit;      // sleep request with no sink
    logic                lowExpired;    // selected low past the unplug time
    logic                unplugNow;     // last sink gone for good
    logic                swapNow;       // selected gone, other still present
    logic                prioMoved;     // priority differs from the acted level
    logic                lateArrival;   // both present, preferred not selected
    logic                settleAbort;   // priority change withdrawn
    logic                settleDone;    // settle wait over
    logic                forceDone;     // forced low over

    // input synchronisers feed only their next stage; three stages so that
    // the last two can be compared before a level is believed
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sA_r <= hps_pkg::SYNC_RESET;
            sB_r <= hps_pkg::SYNC_RESET;
            sP_r <= hps_pkg::SYNC_RESET;
            sL_r <= hps_pkg::SYNC_RESET;
        end else if (clkEn) begin
            sA_r <= {sA_r[1:0], sinkDetectA};
            sB_r <= {sB_r[1:0], sinkDetectB};
            sP_r <= {sP_r[1:0], prioritySelect};
            sL_r <= {sL_r[1:0], lowPowerRequest};
        end
    end

    // accept a level only once stages 1 and 2 agree; a disagreement keeps
    // the previous level, which filters a single unsettled sample
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            in_r <= '0;                         // reads as asleep until pins arrive
        end else if (clkEn) begin
            if (sA_r[1] == sA_r[2]) begin
                in_r.detA <= sA_r[2];
            end
            if (sB_r[1] == sB_r[2]) begin
                in_r.detB <= sB_r[2];
            end
            if (sP_r[1] == sP_r[2]) begin
                in_r.prio <= sP_r[2];
            end
            if (sL_r[1] == sL_r[2]) begin
                in_r.lowPwrReq <= sL_r[2];
            end
        end
    end

    // decoded views of the accepted levels
    always_comb begin
        selDet   = portSelB ? in_r.detB : in_r.detA;
        othDet   = portSelB ? in_r.detA : in_r.detB;
        prefB    = in_r.prio;
        prefDet  = in_r.prio ? in_r.detB : in_r.detA;
        bothHigh = in_r.detA & in_r.detB;
        oneHigh  = in_r.detA ^ in_r.detB;
        noneHigh = ~(in_r.detA | in_r.detB);
    end

    // decisions that the state, port and timer processes must agree on;
    // keeping them in one place stops the three from drifting apart
    always_comb begin
        // a fall of the accepted low-power level while forcing low skips
        // the rest of the forced low
        bypassHit   = !in_r.lowPwrReq && lowPwrPrev_r && (state_r == hps_pkg::HPS_FORCE);
        // sleep request with no sink present
        sleepHit    = !in_r.lowPwrReq && noneHigh;
        lowExpired  = lowCnt_r >= UNPLUG_LIM;
        unplugNow   = noneHigh && lowExpired;
        swapNow     = !selDet && othDet && lowExpired;
        prioMoved   = prefB != prioSeen_r;
        lateArrival = bothHigh && (portSelB != prefB);
        settleAbort = !prioMoved || !bothHigh;
        settleDone  = tmr_r >= SETTLE_LAST;
        forceDone   = tmr_r >= UNPLUG_LAST;
    end

    // low-power level one cycle back, so that a fall can be told from a
    // low that is simply held; reset low to match the accepted level after reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lowPwrPrev_r <= 1'h0;
        end else if (clkEn) begin
            lowPwrPrev_r <= in_r.lowPwrReq;
        end
    end

    // low time of the selected detect, saturating so a long unplug never
    // wraps back into a short interrupt; cleared while asleep
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lowCnt_r <= '0;
        end else if (clkEn) begin
            if (selDet || state_r == hps_pkg::HPS_SLEEP) begin
                lowCnt_r <= '0;                 // present, or nothing to time
            end else if (lowCnt_r != '1) begin
                lowCnt_r <= lowCnt_r + 1'b1;    // still low, keep counting
            end
        end
    end

    // selector mode; the bypass outranks everything, then a sleep request
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= hps_pkg::HPS_SLEEP;
        end else if (clkEn) begin
            if (bypassHit) begin
                state_r <= hps_pkg::HPS_FOLLOW;
            end else if (sleepHit) begin
                state_r <= hps_pkg::HPS_SLEEP;
            end else begin
                unique case (state_r)
                    hps_pkg::HPS_SLEEP: begin
                        // wake on any present sink
                        if (bothHigh || oneHigh) begin
                            state_r <= hps_pkg::HPS_FOLLOW;
                        end
                    end
                    hps_pkg::HPS_FOLLOW: begin
                        if (unplugNow) begin
                            state_r <= hps_pkg::HPS_SLEEP;
                        end else if (swapNow) begin
                            state_r <= hps_pkg::HPS_FOLLOW;      // port swaps, mode stays
                        end else if (bothHigh && prioMoved) begin
                            state_r <= hps_pkg::HPS_SETTLE;
                        end else if (lateArrival) begin
                            state_r <= hps_pkg::HPS_FORCE;
                        end
                        // the other port counts only once the selected one is gone, or when it is the preferred one
                    end
                    hps_pkg::HPS_SETTLE: begin
                        if (settleAbort) begin
                            state_r <= hps_pkg::HPS_FOLLOW;      // glitch ignored
                        end else if (settleDone) begin
                            state_r <= hps_pkg::HPS_FORCE;
                        end
                    end
                    hps_pkg::HPS_FORCE: begin
                        if (noneHigh) begin
                            state_r <= hps_pkg::HPS_SLEEP;       // nobody left to switch to
                        end else if (prefDet && forceDone) begin
                            state_r <= hps_pkg::HPS_FOLLOW;
                        end
                    end
                endcase
            end
        end
    end

    // selected port and the priority level it was chosen under; a port is
    // taken only while its detect is present, except on the bypass, which takes the preferred port unchecked
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            portSelB   <= hps_pkg::PORT_A;
            prioSeen_r <= 1'h0;
        end else if (clkEn) begin
            if (bypassHit) begin
                portSelB   <= prefB;                     // jump straight over
                prioSeen_r <= prefB;
            end else if (!sleepHit) begin
                unique case (state_r)
                    hps_pkg::HPS_SLEEP: begin
                        if (bothHigh) begin
                            portSelB   <= prefB;
                            prioSeen_r <= prefB;
                        end else if (oneHigh) begin
                            portSelB   <= in_r.detB;     // the one present
                            prioSeen_r <= prefB;
                        end
                    end
                    hps_pkg::HPS_FOLLOW: begin
                        if (!unplugNow && swapNow) begin
                            portSelB   <= ~portSelB;
                            prioSeen_r <= prefB;
                        end
                    end
                    hps_pkg::HPS_SETTLE: begin
                        // the port holds while the pin settles
                    end
                    hps_pkg::HPS_FORCE: begin
                        if (!noneHigh && prefDet && forceDone) begin
                            portSelB   <= prefB;
                            prioSeen_r <= prefB;
                        end
                    end
                endcase
            end
        end
    end

    // shared countdown; settle and forced low never overlap, which saves a
    // second wide counter; it rests at zero outside those two modes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tmr_r <= '0;
        end else if (clkEn) begin
            if (bypassHit || sleepHit) begin
                tmr_r <= '0;
            end else begin
                unique case (state_r)
                    hps_pkg::HPS_SLEEP: begin
                        tmr_r <= '0;
                    end
                    hps_pkg::HPS_FOLLOW: begin
                        tmr_r <= '0;                     // every wait starts from zero
                    end
                    hps_pkg::HPS_SETTLE: begin
                        if (settleDone) begin
                            tmr_r <= '0;                 // forced low starts afresh
                        end else if (!settleAbort) begin
                            tmr_r <= tmr_r + 1'b1;
                        end
                    end
                    hps_pkg::HPS_FORCE: begin
                        if (!prefDet) begin
                            tmr_r <= '0;                 // preferred dipped: start over
                        end else if (!forceDone) begin
                            tmr_r <= tmr_r + 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // registered outputs, so the pins never show a decode glitch; short
    // lows pass through with the fixed sync latency only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sourceDetect  <= 1'h0;              // source sees no sink
            linkEnable    <= 1'h0;              // link and aux released
            lowPowerState <= 1'h1;              // wake only on a detect
        end else if (clkEn) begin
            // forced low and sleep both hold the source detect down
            sourceDetect  <= (state_r == hps_pkg::HPS_FOLLOW
                              || state_r == hps_pkg::HPS_SETTLE) && selDet;
            // a low request keeps the I/O released even with a port in use
            lowPowerState <= (state_r == hps_pkg::HPS_SLEEP) || !in_r.lowPwrReq;
            linkEnable    <= (state_r != hps_pkg::HPS_SLEEP) && in_r.lowPwrReq;
        end
    end
endmodule
`default_nettype wire

// ---- logic/hps_pkg.sv ----
`default_nettype none
package hps_pkg;
    // timing in nanoseconds, converted to 125 MHz cycles
    localparam int unsigned CLK_PERIOD_NS      = 8;
    localparam int unsigned SETTLE_TIME_NS     = 1000000;    // priority settle time
    localparam int unsigned UNPLUG_TIME_NS     = 100000000;  // unplug emulation time
    localparam int unsigned SETTLE_CYCLES      = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned UNPLUG_CYCLES      = (UNPLUG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W            = 24;
    localparam int unsigned SYNC_STAGES        = 3;
    localparam logic [2:0]  SYNC_RESET         = 3'h0;
    localparam logic        PORT_A             = 1'h0;
    localparam logic        PORT_B             = 1'h1;

    // selector modes
    typedef enum logic [1:0] {
        HPS_SLEEP,
        HPS_FOLLOW,
        HPS_SETTLE,
        HPS_FORCE
    } hps_state_t;

    // synchronised input bundle
    typedef struct packed {
        logic detA;
        logic detB;
        logic prio;
        logic lowPwrReq;
    } hps_in_t;
endpackage
`default_nettype wire

// ---- test/hps_selector_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// pin-level watch of the selector; latencies lean on the 5-6 cycle pipeline
module hps_selector_monitor #(
    parameter int unsigned SETTLE_CYC = 20,
    parameter int unsigned UNPLUG_CYC = 50
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic sinkDetectA,
    input wire logic sinkDetectB,
    input wire logic prioritySelect,
    input wire logic lowPowerRequest,
    input wire logic sourceDetect,
    input wire logic portSelB,
    input wire logic linkEnable,
    input wire logic lowPowerState
);
    logic selDet;  // detect of the chosen port
    logic onlyA;   // A alone present, source awake
    logic onlyB;   // B alone present
    assign selDet = portSelB ? sinkDetectB : sinkDetectA;
    assign onlyA = sinkDetectA && !sinkDetectB && lowPowerRequest;
    assign onlyB = sinkDetectB && !sinkDetectA;
    default clocking @(posedge clk_sys); endclocking
    // a frozen block holds its outputs, so no rule applies while frozen
    default disable iff (reset || !clkEn);
    sleep_io_a: assert property (lowPowerState |-> !linkEnable)
        else $error("link on while asleep");
    lp_sleep_a: assert property ((!lowPowerRequest)[*8] |=> lowPowerState && !linkEnable)
        else $error("no sleep on request");
    wake_link_a: assert property ($rose(sinkDetectA) && onlyA ##1 onlyA[*7] |=>
        linkEnable && !portSelB) else $error("no wake on A");
    wake_b_a: assert property ($rose(sinkDetectB) && onlyB ##1 onlyB[*7] |=> portSelB)
        else $error("B not chosen");
    low_follow_a: assert property ((!selDet)[*8] |-> !sourceDetect)
        else $error("source high on low port");
    rise_cause_a: assert property ($rose(sourceDetect) |->
        (portSelB ? $past(sinkDetectB, 5) : $past(sinkDetectA, 5))) else $error("bad rise");
    switch_quiet_a: assert property (lowPowerRequest[*8] ##1 $changed(portSelB) |->
        !$past(sourceDetect)) else $error("switch without forced low");
    settle_hold_a: assert property ($changed(prioritySelect) && sinkDetectA && sinkDetectB
        && sourceDetect ##1 (sinkDetectA && sinkDetectB && lowPowerRequest)[*8] |-> sourceDetect)
        else $error("settle time skipped");
    cover property ($rose(portSelB));
    cover property ($fell(portSelB));
    cover property ($rose(linkEnable));
endmodule
bind hps_selector hps_selector_monitor #(.SETTLE_CYC(SETTLE_CYC), .UNPLUG_CYC(UNPLUG_CYC)) mon (
    .clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .sinkDetectA(sinkDetectA),
    .sinkDetectB(sinkDetectB), .prioritySelect(prioritySelect),
    .lowPowerRequest(lowPowerRequest), .sourceDetect(sourceDetect), .portSelB(portSelB),
    .linkEnable(linkEnable), .lowPowerState(lowPowerState));
`default_nettype wire

// ---- test/hps_far_side.sv ----
`timescale 1ns/1ps
`default_nettype none
// two sink connectors and the source's sleep pin, moved on the falling edge
module hps_far_side (
    input  wire logic             clk_sys,
    input  wire hps_pkg::hps_in_t want,  // levels the bench commands
    output var  hps_pkg::hps_in_t pins   // levels seen at the selector pins
);
    initial pins = 4'h1;
    // a brief low on lowPwrReq is how the source skips the forced unplug
    always @(negedge clk_sys) begin
        pins <= want;
    end
endmodule
`default_nettype wire

// ---- test/hps_selector_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch at %0t got %0h expected %0h", $time, g, e); end end
module hps_selector_tb_top;
    logic             clk_sys;
    logic             reset;
    hps_pkg::hps_in_t want;  // detA detB prio lowPwrReq
    hps_pkg::hps_in_t pins;
    logic             srcDet;
    logic             selB;
    logic             linkOn;
    logic             asleep;
    logic             clkEn;
    int               mismatches;
    int               checked;
    hps_far_side far (.clk_sys(clk_sys), .want(want), .pins(pins));
    // short counts keep the forced-low walks brief
    hps_selector #(.SETTLE_CYC(20), .UNPLUG_CYC(50)) dut (.clk_sys(clk_sys), .reset(reset),
        .clkEn(clkEn), .sinkDetectA(pins.detA), .sinkDetectB(pins.detB),
        .prioritySelect(pins.prio), .lowPowerRequest(pins.lowPwrReq), .sourceDetect(srcDet),
        .portSelB(selB), .linkEnable(linkOn), .lowPowerState(asleep));
    initial begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // non-blocking so the far side sees it one falling edge later
    task automatic put(input logic a, input logic b, input logic p, input logic l);
        want <= {a, b, p, l};
    endtask
    task automatic wake_and_pulse;
        put(1, 0, 0, 1);
        cyc(10);
        `CHK({selB, linkOn, srcDet, asleep}, 4'h6)
        put(0, 0, 0, 1);
        cyc(9);
        `CHK(srcDet, 1'h0)
        put(1, 0, 0, 1);
        cyc(9);
        `CHK(srcDet, 1'h1)
        put(1, 0, 1, 1);
        cyc(40);
        `CHK({selB, srcDet}, 2'h1)
        put(1, 0, 0, 1);
        cyc(10);
    endtask
    task automatic prio_switch;
        put(1, 1, 0, 1);
        cyc(30);
        `CHK({selB, srcDet}, 2'h1)
        put(1, 1, 1, 1);
        cyc(12);
        `CHK({selB, srcDet}, 2'h1)
        cyc(28);
        `CHK({selB, srcDet}, 2'h0)
        cyc(50);
        `CHK({selB, srcDet}, 2'h3)
    endtask
    task automatic lose_selected;
        put(1, 0, 1, 1);
        cyc(30);
        `CHK({selB, srcDet}, 2'h2)
        cyc(60);
        `CHK({selB, srcDet}, 2'h1)
    endtask
    // a short dip of the preferred port must restart the countdown
    task automatic restart_force;
        put(1, 1, 1, 1);
        cyc(30);
        `CHK({selB, srcDet}, 2'h0)
        put(1, 0, 1, 1);
        cyc(4);
        put(1, 1, 1, 1);
        cyc(46);
        `CHK({selB, srcDet}, 2'h0)
        cyc(30);
        `CHK({selB, srcDet}, 2'h3)
    endtask
    task automatic bypass_force;
        put(1, 1, 0, 1);
        cyc(40);
        `CHK({selB, srcDet}, 2'h2)
        put(1, 1, 0, 0);
        cyc(3);
        put(1, 1, 0, 1);
        cyc(12);
        `CHK(selB, 1'h0)
        cyc(20);
    endtask
    task automatic lp_and_unplug;
        put(1, 1, 0, 0);
        cyc(12);
        `CHK({linkOn, asleep, srcDet}, 3'h3)
        put(0, 0, 0, 1);
        cyc(80);
        `CHK({linkOn, asleep, srcDet}, 3'h2)
        put(0, 1, 0, 1);
        cyc(10);
        `CHK({selB, linkOn, asleep, srcDet}, 4'hD)
    endtask
    // a low clock enable holds everything; the pin change lands on release
    task automatic freeze_hold;
        clkEn <= 1'h0;
        put(0, 0, 0, 1);
        cyc(20);
        `CHK({selB, linkOn, asleep, srcDet}, 4'hD)
        clkEn <= 1'h1;
        cyc(12);
        `CHK({selB, linkOn, asleep, srcDet}, 4'hC)
    endtask
    task automatic wrap_up;
        if (mismatches == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // cut a hang well past the expected run of under a thousand cycles
    initial begin
        #(8 * 3000);
        mismatches++;
        wrap_up();
    end
    initial begin
        reset = 1'h1;
        clkEn = 1'h1;
        want = 4'h1;
        mismatches = 0;
        checked = 0;
        cyc(4);
        reset <= 1'h0;
        cyc(4);
        wake_and_pulse();
        prio_switch();
        lose_selected();
        restart_force();
        bypass_force();
        lp_and_unplug();
        freeze_hold();
        wrap_up();
    end
endmodule
`default_nettype wire
